/* core/clock_divider_pkg.sv */
// types and shared decode for the system and pwm clock divider
`include "clock_divider_regs.svh"

package clock_divider_pkg;

    // ======================================================================
    // types
    typedef logic [3:0]  sys_divisor_t;
    typedef logic [2:0]  pwm_code_t;
    typedef logic [5:0]  pwm_mask_t;
    typedef logic [`CLKDIV_ADDR_W-1:0] reg_addr_t;

    typedef enum logic {
        source_oscillator = 1'b0,
        source_pll        = 1'b1
    } clock_source_t;

    // ======================================================================
    // decode
    // mask of low counter bits that must all be one for a pwm edge
    function automatic pwm_mask_t pwm_mask(input pwm_code_t code);
        logic [6:0] ratio;
        ratio = `PWM_MASK_UNIT << code;
        if (code >= `PWM_PREDIVISOR_MAX_CODE) begin
            pwm_mask = `PWM_MASK_MAX;
        end else begin
            pwm_mask = 6'(ratio - 7'h01);
        end
    endfunction

endpackage

/* core/clock_divider_regs.svh */
// register offsets, field positions and reset values of the clock divider
`ifndef CLOCK_DIVIDER_REGS_SVH
`define CLOCK_DIVIDER_REGS_SVH

// ==========================================================================
// bus geometry and offsets
`define CLKDIV_ADDR_W                 12
`define RUN_MODE_CLOCK_CONFIG_OFFSET  12'h060

// ==========================================================================
// field positions of run_mode_clock_config
`define SYSTEM_DIVISOR_MSB            26
`define SYSTEM_DIVISOR_LSB            23
`define SYSTEM_DIVIDER_ENABLE_BIT     22
`define PWM_DIVIDER_ENABLE_BIT        20
`define PWM_PREDIVISOR_MSB            19
`define PWM_PREDIVISOR_LSB            17
`define PLL_POWER_DOWN_BIT            13
`define RESERVED_ONE_BIT              12
`define BYPASS_BIT                    11

// ==========================================================================
// reset values and encodings
`define SYSTEM_DIVISOR_RESET          4'hF
`define SYSTEM_DIVIDER_ENABLE_RESET   1'h0
`define PWM_DIVIDER_ENABLE_RESET      1'h0
`define PWM_PREDIVISOR_RESET          3'h7
`define PLL_POWER_DOWN_RESET          1'h1
`define BYPASS_RESET                  1'h1
`define RESERVED_ONE_VALUE            1'h1
`define PWM_PREDIVISOR_MAX_CODE       3'h5
`define PWM_MASK_MAX                  6'h3F
`define PWM_MASK_UNIT                 7'h02

`endif

/* core/pwm_predivider.sv */
// power-of-two predivider that derives the pwm timing tick from system ticks
`timescale 1ns/1ps
`default_nettype none

module pwm_predivider
    import clock_divider_pkg::*;
(
    input  wire logic      clock,
    input  wire logic      resetn,
    input  wire logic      sys_tick_d,
    input  wire logic      divider_enable,
    input  wire pwm_code_t predivisor,
    output logic           pwm_tick_q
);

    // ======================================================================
    // free-running count of system ticks
    // a free counter keeps every ratio aligned to one phase; the trade-off is
    // that a code change may give one short pwm period before the new ratio
    logic [5:0] tick_count_q;
    pwm_mask_t  mask;

    assign mask = pwm_mask(predivisor);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tick_count_q <= 6'h00;
        end else if (sys_tick_d) begin
            tick_count_q <= tick_count_q + 6'h01;
        end
    end

    // ======================================================================
    // tick registered together with the system tick, so edges coincide
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pwm_tick_q <= 1'b0;
        end else begin
            pwm_tick_q <= sys_tick_d
                          & (~divider_enable
                             | ((tick_count_q & mask) == mask));
        end
    end

    // ======================================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_pwm_ratio_phase: assert property (
        (pwm_tick_q && $past(divider_enable))
            |-> (($past(tick_count_q) & $past(mask)) == $past(mask)))
        else $error("pwm tick off its power-of-two phase");

    a_pwm_top_codes: assert property (
        (predivisor >= 3'h5) |-> (mask == 6'h3F))
        else $error("pwm codes five to seven must divide by 64");

endmodule

`default_nettype wire

/* core/system_and_pwm_clock_divider.sv */
// run-mode clock configuration register, system clock divider and pwm divider
`timescale 1ns/1ps
`default_nettype none

`include "clock_divider_regs.svh"

// How it works
// - a four-bit system divisor, reset to all ones, sets the ratio applied to the pll or oscillator source chosen by bypass.
// - with the pll in use, a programmed divisor below the minimum is replaced by the minimum.
// - with the pll not in use, the programmed divisor applies as written even below the minimum.
// - the divider-enable bit, reset to zero, takes the system clock from the divider output when set.
// - selecting the pll always routes the system clock through the divider, whatever the enable bit says.
// - when the alternate override is set, the alternate divisor replaces this register's divisor.
// - the pwm-divider enable bit, reset to zero, takes the pwm clock from the pwm divider when set.
// - the pwm predivisor divides by 2, 4, 8, 16, 32 for codes 0 to 4 and by 64 for 5 to 7, reset code 7.
// - the pwm clock uses power-of-two ratios only and rises on a system clock rising edge with no offset.
// - the pll power-down bit drives the pll power-down output directly and resets to one.
// - bypass, reset to one, selects the oscillator; clear, the system clock is the pll divided down.
// - reserved bits 21, 16:14 and 10 read zero and bit 12 reads one.
module system_and_pwm_clock_divider
    import clock_divider_pkg::*;
(
    input  wire logic         clock,
    input  wire logic         resetn,
    input  wire reg_addr_t    addr,
    input  wire logic [31:0]  wdata,
    input  wire logic         wr_strobe,
    input  wire logic         rd_strobe,
    output logic [31:0]       rdata,
    input  wire logic         osc_clk_in,
    input  wire logic         pll_clk_in,
    input  wire sys_divisor_t minimum_system_divisor,
    input  wire logic         alternate_config_override,
    input  wire sys_divisor_t alternate_system_divisor,
    output logic              pll_power_down,
    output logic              sys_clk_tick,
    output logic              pwm_clk_tick,
    output logic              sys_source_is_pll,
    output sys_divisor_t      effective_divisor
);

    // ======================================================================
    // address decode, shared by the strobes and the checks
    function automatic logic hits_config(input reg_addr_t a);
        hits_config = (a == `RUN_MODE_CLOCK_CONFIG_OFFSET);
    endfunction

    // ======================================================================
    // register fields
    sys_divisor_t  system_divisor_q;
    logic          system_divider_enable_q;
    logic          pwm_divider_enable_q;
    pwm_code_t     pwm_predivisor_q;
    logic          pll_power_down_q;
    logic          bypass_q;
    logic          config_write;
    logic          config_read;
    logic [31:0]   config_image;

    assign config_write = wr_strobe && hits_config(addr);
    assign config_read  = rd_strobe && hits_config(addr);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            system_divisor_q        <= `SYSTEM_DIVISOR_RESET;
            system_divider_enable_q <= `SYSTEM_DIVIDER_ENABLE_RESET;
            pwm_divider_enable_q    <= `PWM_DIVIDER_ENABLE_RESET;
            pwm_predivisor_q        <= `PWM_PREDIVISOR_RESET;
            pll_power_down_q        <= `PLL_POWER_DOWN_RESET;
            bypass_q                <= `BYPASS_RESET;
        end else if (config_write) begin
            system_divisor_q        <= wdata[`SYSTEM_DIVISOR_MSB:`SYSTEM_DIVISOR_LSB];
            system_divider_enable_q <= wdata[`SYSTEM_DIVIDER_ENABLE_BIT];
            pwm_divider_enable_q    <= wdata[`PWM_DIVIDER_ENABLE_BIT];
            pwm_predivisor_q        <= wdata[`PWM_PREDIVISOR_MSB:`PWM_PREDIVISOR_LSB];
            pll_power_down_q        <= wdata[`PLL_POWER_DOWN_BIT];
            bypass_q                <= wdata[`BYPASS_BIT];
        end
    end

    // unimplemented and reserved positions read zero, bit 12 reads one
    always_comb begin
        config_image = 32'h0000_0000;
        config_image[`SYSTEM_DIVISOR_MSB:`SYSTEM_DIVISOR_LSB] = system_divisor_q;
        config_image[`SYSTEM_DIVIDER_ENABLE_BIT]              = system_divider_enable_q;
        config_image[`PWM_DIVIDER_ENABLE_BIT]                 = pwm_divider_enable_q;
        config_image[`PWM_PREDIVISOR_MSB:`PWM_PREDIVISOR_LSB] = pwm_predivisor_q;
        config_image[`PLL_POWER_DOWN_BIT]                     = pll_power_down_q;
        config_image[`RESERVED_ONE_BIT]                       = `RESERVED_ONE_VALUE;
        config_image[`BYPASS_BIT]                             = bypass_q;
    end

    // ======================================================================
    // read port: data valid only in the cycle after the strobe
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata <= 32'h0000_0000;
        end else if (config_read) begin
            rdata <= config_image;
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    // ======================================================================
    // pll power-down pin follows the bit with no extra logic
    assign pll_power_down = pll_power_down_q;

    // ======================================================================
    // source clock synchronisers and rising-edge detection
    // both source clocks are sampled, so each must stay below half the core rate
    logic [1:0] src_meta_q;
    logic [1:0] src_sync_q;
    logic [1:0] src_prev_q;
    logic       osc_edge;
    logic       pll_edge;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            src_meta_q <= 2'h0;
            src_sync_q <= 2'h0;
            src_prev_q <= 2'h0;
        end else begin
            src_meta_q <= {pll_clk_in, osc_clk_in};
            src_sync_q <= src_meta_q;
            src_prev_q <= src_sync_q;
        end
    end

    assign osc_edge = src_sync_q[0] & ~src_prev_q[0];
    assign pll_edge = src_sync_q[1] & ~src_prev_q[1];

    // ======================================================================
    // source selection and divisor choice
    clock_source_t source;
    sys_divisor_t  raw_divisor;
    sys_divisor_t  divisor;
    logic          use_divider;
    logic          source_edge;

    assign source      = bypass_q ? source_oscillator : source_pll;
    assign source_edge = (source == source_pll) ? pll_edge : osc_edge;
    assign use_divider = system_divider_enable_q
                         | (source == source_pll);
    assign raw_divisor = alternate_config_override ? alternate_system_divisor
                                                   : system_divisor_q;

    always_comb begin
        divisor = raw_divisor;
        if ((source == source_pll) && (raw_divisor < minimum_system_divisor)) begin
            divisor = minimum_system_divisor;
        end
    end

    // ======================================================================
    // system clock divider: divisor code n divides the source by n + 1
    sys_divisor_t div_count_q;
    logic         div_wrap;
    logic         sys_tick_d;

    assign div_wrap   = div_count_q >= divisor;
    assign sys_tick_d = source_edge & (~use_divider | div_wrap);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            div_count_q <= 4'h0;
        end else if (source_edge) begin
            if (!use_divider || div_wrap) begin
                div_count_q <= 4'h0;
            end else begin
                div_count_q <= div_count_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sys_clk_tick      <= 1'b0;
            sys_source_is_pll <= 1'b0;
            effective_divisor <= `SYSTEM_DIVISOR_RESET;
        end else begin
            sys_clk_tick      <= sys_tick_d;
            sys_source_is_pll <= (source == source_pll);
            effective_divisor <= divisor;
        end
    end

    // ======================================================================
    // pwm reference, registered beside the system tick
    pwm_predivider u_pwm_predivider (
        .clock          (clock),
        .resetn         (resetn),
        .sys_tick_d     (sys_tick_d),
        .divider_enable (pwm_divider_enable_q),
        .predivisor     (pwm_predivisor_q),
        .pwm_tick_q     (pwm_clk_tick)
    );

    // ======================================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_config_read;
        rd_strobe && (addr == `RUN_MODE_CLOCK_CONFIG_OFFSET);
    endsequence

    sequence s_config_write;
        wr_strobe && (addr == `RUN_MODE_CLOCK_CONFIG_OFFSET);
    endsequence

    a_reserved_read: assert property (
        s_config_read |=> (rdata[21] == 1'b0) && (rdata[16:14] == 3'h0)
                          && (rdata[10] == 1'b0) && (rdata[12] == 1'b1))
        else $error("reserved bits read wrong");

    a_divisor_write: assert property (
        s_config_write ##1 (rd_strobe && (addr == `RUN_MODE_CLOCK_CONFIG_OFFSET))
            |=> (rdata[26:23] == $past(wdata[26:23], 2)))
        else $error("system divisor did not store the written value");

    a_power_down_pin: assert property (
        s_config_write |=> (pll_power_down == $past(wdata[13])))
        else $error("pll power-down pin did not follow the written bit");

    a_pll_min_clamp: assert property (
        (!bypass_q && (raw_divisor < minimum_system_divisor))
            |=> (effective_divisor == $past(minimum_system_divisor)))
        else $error("pll divisor below minimum was not clamped");

    a_osc_no_clamp: assert property (
        (bypass_q && !alternate_config_override)
            |=> (effective_divisor == $past(system_divisor_q)))
        else $error("oscillator divisor was altered");

    a_alt_override: assert property (
        (alternate_config_override && bypass_q)
            |=> (effective_divisor == $past(alternate_system_divisor)))
        else $error("alternate divisor not used under override");

    a_osc_passthru: assert property (
        (bypass_q && !system_divider_enable_q && osc_edge) |=> sys_clk_tick)
        else $error("undivided oscillator edge did not tick the system clock");

    a_pll_divided: assert property (
        (sys_clk_tick && sys_source_is_pll)
            |-> ($past(div_count_q) >= $past(divisor)))
        else $error("pll path ticked without passing the divider");

    a_pwm_aligned: assert property (
        pwm_clk_tick |-> sys_clk_tick)
        else $error("pwm edge not on a system edge");

    a_pwm_undivided: assert property (
        (sys_clk_tick && !$past(pwm_divider_enable_q)) |-> pwm_clk_tick)
        else $error("pwm reference not the system clock with divider off");

    // cheap invariants: a broken decode shows up here long before a count does
    a_rdata_idle: assert property (
        !(rd_strobe && hits_config(addr)) |=> (rdata == 32'h0000_0000))
        else $error("read data not zero outside a config read");

    a_read_bypass: assert property (
        s_config_read |=> (rdata[11] == $past(bypass_q)))
        else $error("bypass bit read back wrong");

    a_source_select: assert property (
        sys_source_is_pll == !$past(bypass_q))
        else $error("system source does not follow bypass");

    a_divisor_hold: assert property (
        !(wr_strobe && hits_config(addr)) |=> $stable(system_divisor_q))
        else $error("system divisor changed without a write");

    a_power_down_hold: assert property (
        !(wr_strobe && hits_config(addr)) |=> $stable(pll_power_down))
        else $error("pll power-down changed without a write");

    // source pulses are at least two core clocks wide, so ticks never abut
    a_tick_single: assert property (
        sys_clk_tick |=> !sys_clk_tick)
        else $error("system tick wider than one cycle");

    a_undivided_source: assert property (
        (bypass_q && !system_divider_enable_q) |-> (sys_tick_d == osc_edge))
        else $error("undivided oscillator path does not pass every edge");

    a_clamp_floor: assert property (
        sys_source_is_pll |-> (effective_divisor >= $past(minimum_system_divisor)))
        else $error("pll divisor below the minimum");

    a_override_pll: assert property (
        (alternate_config_override && !bypass_q
            && (alternate_system_divisor >= minimum_system_divisor))
            |=> (effective_divisor == $past(alternate_system_divisor)))
        else $error("alternate divisor not used on the pll path");

endmodule

`default_nettype wire

/* tb/system_and_pwm_clock_divider_tb_top.sv */
// self-checking bench for the system and pwm clock divider
`timescale 1ns/1ps
`default_nettype none
`include "clock_divider_regs.svh"

module system_and_pwm_clock_divider_tb_top
    import clock_divider_pkg::*;
();
    // ======================================================================
    // signals
    logic         clock;
    logic         resetn;
    reg_addr_t    addr;
    logic [31:0]  wdata;
    logic         wr_strobe;
    logic         rd_strobe;
    logic [31:0]  rdata;
    logic         osc_clk_in;
    logic         pll_clk_in;
    sys_divisor_t minimum_system_divisor;
    logic         alternate_config_override;
    sys_divisor_t alternate_system_divisor;
    logic         pll_power_down;
    logic         sys_clk_tick;
    logic         pwm_clk_tick;
    logic         sys_source_is_pll;
    sys_divisor_t effective_divisor;
    int           fails;
    int           n_compared;
    int           n_sys;
    int           n_pwm;
    int           n_stray;
    logic [31:0]  v;

    system_and_pwm_clock_divider u_system_and_pwm_clock_divider (
        .clock                     (clock),
        .resetn                    (resetn),
        .addr                      (addr),
        .wdata                     (wdata),
        .wr_strobe                 (wr_strobe),
        .rd_strobe                 (rd_strobe),
        .rdata                     (rdata),
        .osc_clk_in                (osc_clk_in),
        .pll_clk_in                (pll_clk_in),
        .minimum_system_divisor    (minimum_system_divisor),
        .alternate_config_override (alternate_config_override),
        .alternate_system_divisor  (alternate_system_divisor),
        .pll_power_down            (pll_power_down),
        .sys_clk_tick              (sys_clk_tick),
        .pwm_clk_tick              (pwm_clk_tick),
        .sys_source_is_pll         (sys_source_is_pll),
        .effective_divisor         (effective_divisor)
    );

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // tick counters; a pwm tick without a system tick would be a phase offset
    always @(posedge clock) begin
        if (sys_clk_tick === 1'b1) n_sys++;
        if (pwm_clk_tick === 1'b1) n_pwm++;
        if (pwm_clk_tick === 1'b1 && sys_clk_tick !== 1'b1) n_stray++;
    end

    // ======================================================================
    // shared tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input reg_addr_t a, input logic [31:0] d);
        @(posedge clock);
        addr      <= a;
        wdata     <= d;
        wr_strobe <= 1'b1;
        @(posedge clock);
        wr_strobe <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample there
    task automatic rd(input reg_addr_t a, output logic [31:0] d);
        @(posedge clock);
        addr      <= a;
        rd_strobe <= 1'b1;
        @(posedge clock);
        rd_strobe <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic cfg(input sys_divisor_t dv, input logic sen, input logic pen,
                       input pwm_code_t pc, input logic pd, input logic byp);
        wr(`RUN_MODE_CLOCK_CONFIG_OFFSET,
           {5'h00, dv, sen, 1'b0, pen, pc, 3'h0, pd, 1'h1, byp, 11'h000});
        repeat (2) @(posedge clock);
    endtask

    // source pulses last three core clocks high and low, slower than clock/2
    task automatic edges(input logic use_pll, input int n);
        @(posedge clock);
        repeat (n) begin
            if (use_pll) pll_clk_in <= 1'b1; else osc_clk_in <= 1'b1;
            repeat (3) @(posedge clock);
            if (use_pll) pll_clk_in <= 1'b0; else osc_clk_in <= 1'b0;
            repeat (3) @(posedge clock);
        end
        repeat (8) @(posedge clock);
    endtask

    // warm-up edges settle the divider phase before counting starts
    task automatic count(input logic use_pll, input int warm, input int n);
        edges(use_pll, warm);
        n_sys   = 0;
        n_pwm   = 0;
        n_stray = 0;
        edges(use_pll, n);
    endtask

    // ======================================================================
    // scenarios
    task automatic t_reset();
        rd(`RUN_MODE_CLOCK_CONFIG_OFFSET, v);
        check("reset image", v, 32'h078E_3800);
        check("pd reset", 32'(pll_power_down), 32'h1);
        check("src reset", 32'(sys_source_is_pll), 32'h0);
        check("div reset", 32'(effective_divisor), 32'hF);
        count(1'b0, 2, 6);
        check("osc undivided", 32'(n_sys), 32'h6);
        check("pwm undivided", 32'(n_pwm), 32'h6);
    endtask

    task automatic t_regs();
        wr(`RUN_MODE_CLOCK_CONFIG_OFFSET, 32'hFFFF_FFFF);
        rd(`RUN_MODE_CLOCK_CONFIG_OFFSET, v);
        check("all ones", v, 32'h07DE_3800);
        @(posedge clock);
        #1 check("rdata drop", rdata, 32'h0000_0000);
        wr(12'h064, 32'h0000_0000);
        rd(`RUN_MODE_CLOCK_CONFIG_OFFSET, v);
        check("unmapped write", v, 32'h07DE_3800);
        rd(12'h064, v);
        check("unmapped read", v, 32'h0000_0000);
        wr(`RUN_MODE_CLOCK_CONFIG_OFFSET, 32'h0000_0000);
        rd(`RUN_MODE_CLOCK_CONFIG_OFFSET, v);
        check("all zeros", v, 32'h0000_1000);
        check("pd cleared", 32'(pll_power_down), 32'h0);
        check("src pll", 32'(sys_source_is_pll), 32'h1);
    endtask

    task automatic t_system_divisor();
        sys_divisor_t tab [3];
        tab = '{4'h0, 4'h2, 4'h5};
        minimum_system_divisor <= 4'h8;
        foreach (tab[i]) begin
            cfg(tab[i], 1'b1, 1'b0, 3'h0, 1'b1, 1'b1);
            check("osc divisor", 32'(effective_divisor), 32'(tab[i]));
            count(1'b0, 8, 4 * (int'(tab[i]) + 1));
            check("osc divided", 32'(n_sys), 32'h4);
        end
    endtask

    task automatic t_pll();
        // divider enable left clear: the pll path must divide anyway
        minimum_system_divisor <= 4'h4;
        cfg(4'h1, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0);
        check("clamp", 32'(effective_divisor), 32'h4);
        count(1'b1, 10, 20);
        check("pll divided", 32'(n_sys), 32'h4);
        count(1'b0, 0, 10);
        check("osc ignored", 32'(n_sys), 32'h0);
        cfg(4'h9, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0);
        check("no clamp", 32'(effective_divisor), 32'h9);
        alternate_config_override <= 1'b1;
        alternate_system_divisor  <= 4'h6;
        repeat (3) @(posedge clock);
        check("override", 32'(effective_divisor), 32'h6);
        alternate_system_divisor <= 4'h2;
        repeat (3) @(posedge clock);
        check("override clamp", 32'(effective_divisor), 32'h4);
        cfg(4'h9, 1'b1, 1'b0, 3'h0, 1'b1, 1'b1);
        check("override osc", 32'(effective_divisor), 32'h2);
        alternate_config_override <= 1'b0;
        repeat (3) @(posedge clock);
    endtask

    task automatic t_pwm();
        int exp;
        for (int c = 0; c < 8; c++) begin
            cfg(4'h0, 1'b0, 1'b1, 3'(c), 1'b1, 1'b1);
            count(1'b0, 64, 128);
            exp = (c >= 5) ? 2 : (128 >> (c + 1));
            check("pwm ratio", 32'(n_pwm), 32'(exp));
            check("pwm phase", 32'(n_stray), 32'h0);
        end
        cfg(4'h0, 1'b0, 1'b0, 3'h3, 1'b1, 1'b1);
        count(1'b0, 2, 16);
        check("pwm bypass", 32'(n_pwm), 32'h10);
    endtask

    // ======================================================================
    // sequence and verdict
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        fails = 0;
        n_compared = 0;
        resetn = 1'b0;
        addr = 12'h000;
        wdata = 32'h0000_0000;
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
        osc_clk_in = 1'b0;
        pll_clk_in = 1'b0;
        minimum_system_divisor = 4'h4;
        alternate_config_override = 1'b0;
        alternate_system_divisor = 4'h0;
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        t_reset();
        t_regs();
        t_system_divisor();
        t_pll();
        t_pwm();
        tally_and_finish();
    end

    // the whole run needs under 15000 cycles
    initial begin
        repeat (60000) @(posedge clock);
        fails++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
